// ---- src/dual_conv_status_mode.sv ----
// status and mode registers for a primary and an auxiliary converter
`default_nettype none
module dual_conv_status_mode
	import conv_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	input wire logic primaryDone,
	input wire logic primaryClamped,
	input wire logic primaryCalFail,
	input wire logic [23:0] primaryResult,
	input wire logic auxDone,
	input wire logic auxClamped,
	input wire logic auxCalFail,
	input wire logic [15:0] auxResult,
	input wire logic refFault,
	input wire logic primaryExtRef,
	input wire logic auxExtRef,
	output logic primaryEnable,
	output logic auxEnable,
	output conv_mode_t modeSelect,
	output logic convReset,
	output logic primaryWriteEn,
	output logic auxWriteEn,
	output logic [23:0] primaryData,
	output logic [15:0] auxData
);
	import conv_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	function automatic logic isCal(input conv_mode_t m);
		isCal = m[2];
	endfunction : isCal

	logic modeWr;
	logic statWr;
	logic modeEn0_q;
	logic modeEn1_q;
	conv_mode_t mode_q;
	logic primaryReady_q;
	logic auxReady_q;
	logic calDone_q;
	logic refMissing_q;
	logic primaryError_q;
	logic auxError_q;
	logic primaryAccept;
	logic auxAccept;
	logic anyActive;

	assign modeWr = sfrWrEn && sfrAddr == MODE_ADDR;
	assign statWr = sfrWrEn && sfrAddr == STAT_ADDR;
	assign primaryAccept = primaryDone && !primaryReady_q && !modeWr;
	assign auxAccept = auxDone && !auxReady_q && !modeWr;
	assign anyActive = modeEn0_q || modeEn1_q;

	////////////////////////////////////////////////////////////////////////
	// mode register
	always_ff @(posedge clk) begin
		if (rst) begin
			modeEn0_q <= MODE_RESET[BIT_PRIMARY_ENABLE];
			modeEn1_q <= MODE_RESET[BIT_AUX_ENABLE];
			mode_q <= conv_mode_t'(MODE_RESET[2:0]);
		end else if (modeWr) begin
			modeEn0_q <= sfrWrData[BIT_PRIMARY_ENABLE];
			modeEn1_q <= sfrWrData[BIT_AUX_ENABLE];
			mode_q <= conv_mode_t'(sfrWrData[2:0]);
		end else if ((primaryAccept || auxAccept) &&
			(mode_q == MODE_SINGLE || isCal(mode_q))) begin
			mode_q <= MODE_POWER_DOWN;
		end
	end

	assign primaryEnable = modeEn0_q && mode_q != MODE_POWER_DOWN;
	assign auxEnable = modeEn1_q && mode_q != MODE_POWER_DOWN;
	assign modeSelect = mode_q;
	assign convReset = modeWr;
	assign primaryWriteEn = primaryAccept;
	assign auxWriteEn = auxAccept;

	////////////////////////////////////////////////////////////////////////
	// ready flags; hardware set wins over a status-write clear, a mode write blocks the set and clears
	always_ff @(posedge clk) begin
		if (rst) begin
			primaryReady_q <= STAT_RESET[BIT_PRIMARY_READY];
			auxReady_q <= STAT_RESET[BIT_AUX_READY];
		end else begin
			if (primaryAccept)
				primaryReady_q <= 1'b1;
			else if (modeWr || (statWr && !sfrWrData[BIT_PRIMARY_READY]))
				primaryReady_q <= 1'b0;
			if (auxAccept)
				auxReady_q <= 1'b1;
			else if (modeWr || (statWr && !sfrWrData[BIT_AUX_READY]))
				auxReady_q <= 1'b0;
		end
	end

	// calibration done and error flags
	always_ff @(posedge clk) begin
		if (rst) begin
			calDone_q <= STAT_RESET[BIT_CAL_DONE];
			primaryError_q <= STAT_RESET[BIT_PRIMARY_ERROR];
			auxError_q <= STAT_RESET[BIT_AUX_ERROR];
		end else if (modeWr) begin
			calDone_q <= 1'b0;
			primaryError_q <= 1'b0;
			auxError_q <= 1'b0;
		end else begin
			if ((primaryAccept || auxAccept) && isCal(mode_q))
				calDone_q <= 1'b1;
			if (primaryAccept && (primaryClamped ||
				(isCal(mode_q) && primaryCalFail)))
				primaryError_q <= 1'b1;
			if (auxAccept && (auxClamped || (isCal(mode_q) && auxCalFail)))
				auxError_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			refMissing_q <= STAT_RESET[BIT_REF_MISSING];
		else if (anyActive)
			refMissing_q <= refFault;
	end

	////////////////////////////////////////////////////////////////////////
	// result capture; cal results pass too, for coefficient storage
	always_ff @(posedge clk) begin
		if (rst) begin
			primaryData <= '0;
			auxData <= '0;
		end else begin
			if (primaryAccept)
				primaryData <= (refMissing_q && primaryExtRef) ?
					PRIMARY_ALL_ONES : primaryResult;
			if (auxAccept)
				auxData <= (refMissing_q && auxExtRef) ?
					AUX_ALL_ONES : auxResult;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port; reserved bits read zero
	always_ff @(posedge clk) begin
		if (rst)
			sfrRdData <= 8'h00;
		else if (sfrRdEn) begin
			case (sfrAddr)
				MODE_ADDR: sfrRdData <= {2'b00, modeEn0_q, modeEn1_q,
					1'b0, mode_q};
				STAT_ADDR: sfrRdData <= {primaryReady_q, auxReady_q,
					calDone_q, refMissing_q, primaryError_q, auxError_q,
					2'b00};
				default: sfrRdData <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_ready_blocks: assert property (@(posedge clk) disable iff (rst)
		primaryReady_q |-> !primaryWriteEn)
		else $error("primary write while ready set");
	a_ready_sets: assert property (@(posedge clk) disable iff (rst)
		primaryAccept |=> primaryReady_q)
		else $error("primary ready not set");
	a_aux_ready: assert property (@(posedge clk) disable iff (rst)
		auxAccept |=> auxReady_q && !auxWriteEn)
		else $error("aux ready misbehaves");
	a_mode_clears: assert property (@(posedge clk) disable iff (rst)
		modeWr |=> !primaryReady_q && !calDone_q && !primaryError_q)
		else $error("mode write did not clear flags");
	a_single_return: assert property (@(posedge clk) disable iff (rst)
		primaryAccept && mode_q == MODE_SINGLE && !modeWr
		|=> mode_q == MODE_POWER_DOWN)
		else $error("single conversion did not return to power-down");
	a_ref_clamp: assert property (@(posedge clk) disable iff (rst)
		primaryAccept && refMissing_q && primaryExtRef
		|=> primaryData == PRIMARY_ALL_ONES)
		else $error("result not forced to all ones");
	a_clamp_error: assert property (@(posedge clk) disable iff (rst)
		primaryAccept && primaryClamped |=> primaryError_q)
		else $error("clamp did not set primary error");
	a_enable_follows: assert property (@(posedge clk) disable iff (rst)
		modeWr && !sfrWrData[BIT_PRIMARY_ENABLE] |=> !primaryEnable)
		else $error("primary not powered down");

	////////////////////////////////////////////////////////////////////////
	// flag set, clear and hold checks
	a_sw_clear: assert property (@(posedge clk) disable iff (rst)
		statWr && !sfrWrData[BIT_PRIMARY_READY] && !primaryAccept
		|=> !primaryReady_q)
		else $error("software clear of primary ready lost");
	a_ready_survives: assert property (@(posedge clk) disable iff (rst)
		primaryReady_q && !modeWr && !statWr |=> primaryReady_q)
		else $error("primary ready dropped on its own");
	// a blocked result must not leak into the data register
	a_data_blocked: assert property (@(posedge clk) disable iff (rst)
		!primaryAccept |=> $stable(primaryData))
		else $error("primary data changed without accept");
	a_aux_blocks: assert property (@(posedge clk) disable iff (rst)
		auxReady_q |-> !auxWriteEn)
		else $error("aux write while ready set");
	a_cal_done_sets: assert property (@(posedge clk) disable iff (rst)
		(primaryAccept || auxAccept) && isCal(mode_q) |=> calDone_q)
		else $error("calibration done not set");
	// a floating reference only matters while an enable bit is set, even in power-down
	a_ref_tracks: assert property (@(posedge clk) disable iff (rst)
		anyActive |=> refMissing_q == $past(refFault))
		else $error("reference flag does not follow fault");
	a_ref_holds: assert property (@(posedge clk) disable iff (rst)
		!anyActive |=> $stable(refMissing_q))
		else $error("reference flag moved while idle");
	a_aux_ref_clamp: assert property (@(posedge clk) disable iff (rst)
		auxAccept && refMissing_q && auxExtRef
		|=> auxData == AUX_ALL_ONES)
		else $error("aux result not forced to all ones");
	// failure input is ignored outside the calibration modes
	a_cal_fail_error: assert property (@(posedge clk) disable iff (rst)
		primaryAccept && isCal(mode_q) && primaryCalFail
		|=> primaryError_q)
		else $error("failed calibration not flagged");
	a_mode_clears_err: assert property (@(posedge clk) disable iff (rst)
		modeWr |=> !primaryError_q && !auxError_q)
		else $error("mode write left an error flag");
	a_aux_clamp_error: assert property (@(posedge clk) disable iff (rst)
		auxAccept && auxClamped |=> auxError_q)
		else $error("clamp did not set aux error");
	a_aux_cal_fail: assert property (@(posedge clk) disable iff (rst)
		auxAccept && isCal(mode_q) && auxCalFail
		|=> auxError_q)
		else $error("failed aux calibration not flagged");
	a_stat_rsvd: assert property (@(posedge clk) disable iff (rst)
		sfrRdEn && sfrAddr == STAT_ADDR |=> sfrRdData[1:0] == 2'b00)
		else $error("reserved status bits not zero");
	a_rd_holds: assert property (@(posedge clk) disable iff (rst)
		!sfrRdEn |=> $stable(sfrRdData))
		else $error("read data moved without a read");

	////////////////////////////////////////////////////////////////////////
	// enable and mode checks
	a_primary_runs: assert property (@(posedge clk) disable iff (rst)
		modeWr && sfrWrData[BIT_PRIMARY_ENABLE] && sfrWrData[2:0] != 3'h0
		|=> primaryEnable && modeSelect == $past(sfrWrData[2:0]))
		else $error("primary not running in written mode");
	a_aux_enable: assert property (@(posedge clk) disable iff (rst)
		modeWr |=> auxEnable == ($past(sfrWrData[BIT_AUX_ENABLE]) &&
		$past(sfrWrData[2:0]) != 3'h0))
		else $error("aux enable does not follow mode write");
	a_powerdown_off: assert property (@(posedge clk) disable iff (rst)
		modeSelect == MODE_POWER_DOWN |-> !primaryEnable && !auxEnable)
		else $error("converter enabled in power-down");
	// rewriting the same mode still restarts both converters
	a_reset_pulse: assert property (@(posedge clk) disable iff (rst)
		convReset == (sfrWrEn && sfrAddr == MODE_ADDR))
		else $error("converter reset does not match mode write");
	a_cal_return: assert property (@(posedge clk) disable iff (rst)
		(primaryAccept || auxAccept) && isCal(mode_q)
		|=> modeSelect == MODE_POWER_DOWN)
		else $error("calibration did not return to power-down");
	a_cal_clears_rdy: assert property (@(posedge clk) disable iff (rst)
		modeWr && sfrWrData[2] |=> !primaryReady_q && !auxReady_q)
		else $error("calibration write left a ready flag");
	a_mode_rsvd: assert property (@(posedge clk) disable iff (rst)
		sfrRdEn && sfrAddr == MODE_ADDR
		|=> sfrRdData[7:6] == 2'b00 && !sfrRdData[3])
		else $error("reserved mode bits not zero");
endmodule : dual_conv_status_mode
`default_nettype wire

// ---- src/conv_ctrl_pkg.sv ----
// constants and types for the dual converter status and mode block
`default_nettype none
package conv_ctrl_pkg;
	localparam logic [7:0] MODE_ADDR = 8'hD1;
	localparam logic [7:0] STAT_ADDR = 8'hD8;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam int BIT_PRIMARY_READY = 7;
	localparam int BIT_AUX_READY = 6;
	localparam int BIT_CAL_DONE = 5;
	localparam int BIT_REF_MISSING = 4;
	localparam int BIT_PRIMARY_ERROR = 3;
	localparam int BIT_AUX_ERROR = 2;
	localparam int BIT_PRIMARY_ENABLE = 5;
	localparam int BIT_AUX_ENABLE = 4;
	localparam logic [7:0] MODE_WRITE_MASK = 8'h37;
	localparam logic [7:0] STAT_CLEAR_MASK = 8'hC0;
	localparam logic [23:0] PRIMARY_ALL_ONES = 24'hFFFFFF;
	localparam logic [15:0] AUX_ALL_ONES = 16'hFFFF;
	typedef enum logic [2:0] {
		MODE_POWER_DOWN = 3'h0,
		MODE_IDLE = 3'h1,
		MODE_SINGLE = 3'h2,
		MODE_CONTINUOUS = 3'h3,
		MODE_INT_ZERO_CAL = 3'h4,
		MODE_INT_FULL_CAL = 3'h5,
		MODE_SYS_ZERO_CAL = 3'h6,
		MODE_SYS_FULL_CAL = 3'h7
	} conv_mode_t;
endpackage : conv_ctrl_pkg
`default_nettype wire

// ---- verif/conv_partner.sv ----
// converter model: completion pulses and results
`default_nettype none
module conv_partner #(parameter int LAT = 4) (
	input wire logic clk,
	input wire logic rst,
	input wire logic convReset,
	input wire logic primaryEnable,
	input wire logic auxEnable,
	output logic primaryDone,
	output logic auxDone,
	output logic [23:0] primaryResult,
	output logic [15:0] auxResult
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	logic fire;
	assign fire = cnt == LAT - 1;
	always_ff @(posedge clk) begin
		if (rst || convReset || !(primaryEnable || auxEnable)) begin
			cnt <= 0;
		end else begin
			cnt <= fire ? 0 : cnt + 1;
		end
		primaryDone <= fire && primaryEnable && !convReset;
		auxDone <= fire && auxEnable && !convReset;
		// idle value inverted so stale data never matches
		primaryResult <= fire ? 24'h5A5A5A : 24'hA5A5A5;
		auxResult <= fire ? 16'h3C3C : 16'hC3C3;
	end
endmodule : conv_partner
`default_nettype wire

// ---- verif/tb_top.sv ----
// bench for the dual converter status and mode block
`default_nettype none
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin \
	failures++; $display("FAIL t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top;
	import conv_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, sfrWrEn = 0, sfrRdEn = 0, pDone, aDone;
	logic [7:0] sfrAddr = 0, sfrWrData = 0, sfrRdData;
	logic pClamp = 0, aClamp = 0, pFail = 0, aFail = 0, refFault = 0;
	logic pExt = 0, aExt = 0, pEn, aEn, cRst, pWe, aWe;
	logic [23:0] pRes, pData;
	logic [15:0] aRes, aData;
	conv_mode_t modeSel;
	int failures = 0, samplesChecked = 0, cycles = 0, wePulses = 0;
	always #20 clk = ~clk;
	dual_conv_status_mode dual_conv_status_mode_i (.clk(clk), .rst(rst),
		.sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn),
		.sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .primaryDone(pDone),
		.primaryClamped(pClamp), .primaryCalFail(pFail),
		.primaryResult(pRes), .auxDone(aDone), .auxClamped(aClamp),
		.auxCalFail(aFail), .auxResult(aRes), .refFault(refFault),
		.primaryExtRef(pExt), .auxExtRef(aExt), .primaryEnable(pEn),
		.auxEnable(aEn), .modeSelect(modeSel), .convReset(cRst),
		.primaryWriteEn(pWe), .auxWriteEn(aWe), .primaryData(pData),
		.auxData(aData));
	conv_partner conv_partner_i (.clk(clk), .rst(rst), .convReset(cRst),
		.primaryEnable(pEn), .auxEnable(aEn), .primaryDone(pDone),
		.auxDone(aDone), .primaryResult(pRes), .auxResult(aRes));
	////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (pWe === 1'b1) begin
			wePulses++;
		end
		// hang guard, run needs well under 1000 cycles
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrEn <= 1'b1;
		@(posedge clk);
		sfrWrEn <= 1'b0;
	endtask : wr
	task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge clk);
		sfrRdEn <= 1'b0;
		#1;
		`CHK(sfrRdData, e)
	endtask : rd_check
	task automatic summarize;
		$display("checks %0d failures %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////
	task automatic t_single;
		wr(MODE_ADDR, 8'h22);
		repeat (10) @(posedge clk);
		`CHK(pData, 24'h5A5A5A)
		rd_check(STAT_ADDR, 8'h80);
		rd_check(MODE_ADDR, 8'h20);
		wr(STAT_ADDR, 8'hFF);
		rd_check(STAT_ADDR, 8'h80);
		wr(STAT_ADDR, 8'h00);
		rd_check(STAT_ADDR, 8'h00);
	endtask : t_single
	task automatic t_block;
		wePulses = 0;
		wr(MODE_ADDR, 8'h23);
		repeat (20) @(posedge clk);
		`CHK(wePulses, 1)
		wr(MODE_ADDR, 8'h00);
		rd_check(STAT_ADDR, 8'h00);
		`CHK(pEn, 1'b0)
	endtask : t_block
	task automatic t_cal;
		aFail <= 1'b1;
		wr(MODE_ADDR, 8'h15);
		repeat (10) @(posedge clk);
		rd_check(STAT_ADDR, 8'h64);
		rd_check(MODE_ADDR, 8'h10);
		aFail <= 1'b0;
		wr(MODE_ADDR, 8'h11);
		rd_check(STAT_ADDR, 8'h00);
	endtask : t_cal
	task automatic t_ref;
		refFault <= 1'b1;
		pExt <= 1'b1;
		pClamp <= 1'b1;
		wr(MODE_ADDR, 8'h22);
		repeat (10) @(posedge clk);
		`CHK(pData, PRIMARY_ALL_ONES)
		rd_check(STAT_ADDR, 8'h98);
		wr(MODE_ADDR, 8'hC8);
		rd_check(MODE_ADDR, 8'h00);
		rd_check(8'h00, 8'h00);
	endtask : t_ref
	task automatic t_pcal;
		refFault <= 1'b0;
		pClamp <= 1'b0;
		pExt <= 1'b0;
		pFail <= 1'b1;
		wr(MODE_ADDR, 8'h26);
		repeat (10) @(posedge clk);
		`CHK(pData, 24'h5A5A5A)
		rd_check(STAT_ADDR, 8'hA8);
		rd_check(MODE_ADDR, 8'h20);
		pFail <= 1'b0;
		wr(MODE_ADDR, 8'h20);
		rd_check(STAT_ADDR, 8'h00);
	endtask : t_pcal
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_check(MODE_ADDR, 8'h00);
		rd_check(STAT_ADDR, 8'h00);
		t_single();
		t_block();
		t_cal();
		t_ref();
		t_pcal();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
